// ### src/bcc_consts.svh
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// paged control registers, 0x01..0x04 select by block bit
`define BCC_A_MSR 5'h00
`define BCC_A_MODE 5'h01
`define BCC_A_TSCTL 5'h02
`define BCC_A_PFLAG 5'h03
`define BCC_A_STORE0 5'h04
`define BCC_A_STORE1 5'h01
`define BCC_A_OUTMODE 5'h02
`define BCC_A_ICR0 5'h03
`define BCC_A_ICR1 5'h04
`define BCC_A_PAGE_LAST 5'h04

// clock counters
`define BCC_A_HUND 5'h05
`define BCC_A_SEC 5'h06
`define BCC_A_MIN 5'h07
`define BCC_A_HOUR 5'h08
`define BCC_A_DOM 5'h09
`define BCC_A_MON 5'h0A
`define BCC_A_YEAR 5'h0B
`define BCC_A_RAM_LO 5'h0C
`define BCC_A_TWOBIT 5'h0D
`define BCC_A_DOW 5'h0E
`define BCC_A_NA_FIRST 5'h0F
`define BCC_A_NA_LAST 5'h12

// alarm compare bytes
`define BCC_A_CMP_SEC 5'h13
`define BCC_A_CMP_MIN 5'h14
`define BCC_A_CMP_HOUR 5'h15
`define BCC_A_CMP_DOM 5'h16
`define BCC_A_CMP_MON 5'h17
`define BCC_A_CMP_DOW 5'h18

// time save bytes
`define BCC_A_TS_SEC 5'h19
`define BCC_A_TS_MIN 5'h1A
`define BCC_A_TS_HOUR 5'h1B
`define BCC_A_TS_DOM 5'h1C
`define BCC_A_TS_MON 5'h1D
`define BCC_A_RAM_HI 5'h1E
`define BCC_A_RAM_TOP 5'h1F

// field positions
`define BCC_MSR_INT 0
`define BCC_MSR_PFAIL 1
`define BCC_MSR_PER 2
`define BCC_MSR_ALM 3
`define BCC_MSR_BLOCK 6
`define BCC_MODE_12H 2
`define BCC_MODE_RUN 3
`define BCC_TS_EN 7
`define BCC_ICR1_ALM_IE 6
`define BCC_PF_HUND 0
`define BCC_PF_TENTH 1
`define BCC_PF_SEC 2
`define BCC_PF_MIN 3
`define BCC_PF_HOUR 4
`define BCC_PF_DAY 5
`define BCC_HOUR_PM 7

// bits that the counters really use
`define BCC_MASK_SEC 8'h7F
`define BCC_MASK_MIN 8'h7F
`define BCC_MASK_HOUR 8'hBF
`define BCC_MASK_DOM 8'h3F
`define BCC_MASK_MON 8'h1F
`define BCC_MASK_TWOBIT 8'h03
`define BCC_MSR_WMASK 8'h40

// reset values
`define BCC_RST_BYTE 8'h00

// timing
`define BCC_CLK_HZ 25000000
`define BCC_MID_HZ 32000
`define BCC_TICK_HZ 100

`endif

// ### src/bcc_pkg.sv
package bcc_pkg;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [4:0] addr;
        logic [7:0] data;
    } bcc_pin_t;

    typedef struct packed {
        bcc_pin_t s1;
        bcc_pin_t s2;
        logic rd_prev;
        logic wr_prev;
        logic [4:0] wa;
        logic [7:0] wd;
        logic [7:0] rdata;
        logic [31:0][7:0] mem;
        logic [3:0][7:0] pg1;
        logic [7:0] msr;
        logic [7:0] pflag;
        logic [15:0] div1;
        logic [15:0] div2;
        logic tick_dly;
    } bcc_state_t;

endpackage : bcc_pkg

// ### src/bcc_core.sv
// Contract
// - eight BCD counters, hundredths to years, one tick
// - weekday, day, month wrap to one
// - twelve-hour wraps to one, meridiem toggles
// - meridiem sits in hours bit seven
// - all other counters wrap to zero
// - counters need no power-up initialisation
// - status bit selects visible control block
// - enabled periodic interrupt raised at rollover
// - time-save enable copies counters continuously
// - enable falling freezes coherent snapshot
// - snapshot touches only used counter bits
// - save disabled, snapshot bytes are storage
// - start/stop low halts counting and carries
// - stopping resets the prescaler
// - prescaler divides to mid rate, 100 Hz
// - any periodic flag access clears flags
// - status alarm, periodic cleared by one
`include "bcc_consts.svh"

module bcc_core #(
    parameter int PRE_DIV1 = `BCC_CLK_HZ / `BCC_MID_HZ,
    parameter int PRE_DIV2 = `BCC_MID_HZ / `BCC_TICK_HZ
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    output logic intr_n_out,
    output logic intr_oe_n_out
);

    bcc_pkg::bcc_state_t q;
    bcc_pkg::bcc_state_t d;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] >= 4'h9) begin
            bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_inc = 8'(v + 8'h01);
        end
    endfunction : bcd_inc

    function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
               (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        unique case (mon)
            8'h02: last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction : last_day

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] cnt, input logic [7:0] mask);
        merge = (old & ~mask) | (cnt & mask);
    endfunction : merge

    logic run;
    logic twelve;
    logic tick;
    logic rd_act;
    logic wr_act;
    logic wr_done;
    logic rd_done;
    logic block1;
    logic intr;
    logic alarm_match;
    logic [7:0] cnt_hour;
    logic [7:0] per_set;
    logic [7:0] icr0;
    logic [7:0] icr1;
    logic [5:0] cmp_eq;

    assign run = q.mem[`BCC_A_MODE][`BCC_MODE_RUN];
    assign twelve = q.mem[`BCC_A_MODE][`BCC_MODE_12H];
    // selects which control block answers at the paged addresses
    assign block1 = q.msr[`BCC_MSR_BLOCK];
    assign icr0 = q.pg1[3'(`BCC_A_ICR0 - 5'h01)];
    assign icr1 = q.pg1[3'(`BCC_A_ICR1 - 5'h01)];
    assign rd_act = !q.s2.cs_n && !q.s2.rd_n;
    assign wr_act = !q.s2.cs_n && !q.s2.wr_n;
    assign wr_done = q.wr_prev && !wr_act;
    assign rd_done = q.rd_prev && !rd_act;
    assign tick = run && (q.div1 == 16'(PRE_DIV1 - 1)) && (q.div2 == 16'(PRE_DIV2 - 1));
    assign intr = q.msr[`BCC_MSR_PER] || (q.msr[`BCC_MSR_ALM] && icr1[`BCC_ICR1_ALM_IE]);

    // a disabled compare byte counts as always equal
    assign cmp_eq[0] = q.mem[`BCC_A_SEC] == q.mem[`BCC_A_CMP_SEC];
    assign cmp_eq[1] = q.mem[`BCC_A_MIN] == q.mem[`BCC_A_CMP_MIN];
    assign cmp_eq[2] = q.mem[`BCC_A_HOUR] == q.mem[`BCC_A_CMP_HOUR];
    assign cmp_eq[3] = q.mem[`BCC_A_DOM] == q.mem[`BCC_A_CMP_DOM];
    assign cmp_eq[4] = q.mem[`BCC_A_MON] == q.mem[`BCC_A_CMP_MON];
    assign cmp_eq[5] = q.mem[`BCC_A_DOW] == q.mem[`BCC_A_CMP_DOW];
    assign alarm_match = (&(cmp_eq | ~icr1[5:0])) && (|icr1[5:0]);

    always_comb begin
        logic c_sec;
        logic c_min;
        logic c_hour;
        logic c_day;
        logic c_mon;
        logic c_year;
        logic pm;
        logic [7:0] h;
        logic [7:0] rd_val;
        c_sec = 1'b0;
        c_min = 1'b0;
        c_hour = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_year = 1'b0;
        pm = q.mem[`BCC_A_HOUR][`BCC_HOUR_PM];
        h = {2'b00, q.mem[`BCC_A_HOUR][5:0]};
        rd_val = `BCC_RST_BYTE;
        per_set = 8'h00;
        cnt_hour = q.mem[`BCC_A_HOUR];
        d = q;

        // pins pass two flops before any logic looks at them
        d.s1 = {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in};
        d.s2 = q.s1;
        d.rd_prev = rd_act;
        d.wr_prev = wr_act;
        d.tick_dly = tick;

        if (!run) begin
            d.div1 = 16'h0000;
            d.div2 = 16'h0000;
        end else if (q.div1 == 16'(PRE_DIV1 - 1)) begin
            d.div1 = 16'h0000;
            d.div2 = (q.div2 == 16'(PRE_DIV2 - 1)) ? 16'h0000 : 16'(q.div2 + 16'h0001);
        end else begin
            d.div1 = 16'(q.div1 + 16'h0001);
        end

        // no tick and no carry while stopped
        if (tick) begin
            // whole chain advanced from one tick
            per_set[`BCC_PF_HUND] = 1'b1;
            per_set[`BCC_PF_TENTH] = q.mem[`BCC_A_HUND][3:0] == 4'h9;
            c_sec = q.mem[`BCC_A_HUND] == 8'h99;
            d.mem[`BCC_A_HUND] = c_sec ? 8'h00 : bcd_inc(q.mem[`BCC_A_HUND]);
            if (c_sec) begin
                per_set[`BCC_PF_SEC] = 1'b1;
                c_min = q.mem[`BCC_A_SEC] == 8'h59;
                d.mem[`BCC_A_SEC] = c_min ? 8'h00 : bcd_inc(q.mem[`BCC_A_SEC]);
            end
            if (c_min) begin
                per_set[`BCC_PF_MIN] = 1'b1;
                c_hour = q.mem[`BCC_A_MIN] == 8'h59;
                d.mem[`BCC_A_MIN] = c_hour ? 8'h00 : bcd_inc(q.mem[`BCC_A_MIN]);
            end
            if (c_hour) begin
                per_set[`BCC_PF_HOUR] = 1'b1;
                if (twelve) begin
                    if (h == 8'h12) begin
                        h = 8'h01;
                    end else if (h == 8'h11) begin
                        h = 8'h12;
                        c_day = pm;
                        pm = !pm;
                    end else begin
                        h = bcd_inc(h);
                    end
                end else begin
                    c_day = h == 8'h23;
                    h = c_day ? 8'h00 : bcd_inc(h);
                end
                cnt_hour = {pm, 1'b0, h[5:0]};
                d.mem[`BCC_A_HOUR] = cnt_hour;
            end
            if (c_day) begin
                per_set[`BCC_PF_DAY] = 1'b1;
                c_mon = q.mem[`BCC_A_DOM] == last_day(q.mem[`BCC_A_MON], q.mem[`BCC_A_YEAR]);
                d.mem[`BCC_A_DOM] = c_mon ? 8'h01 : bcd_inc(q.mem[`BCC_A_DOM]);
                d.mem[`BCC_A_DOW] = (q.mem[`BCC_A_DOW] == 8'h07) ? 8'h01 : bcd_inc(q.mem[`BCC_A_DOW]);
            end
            if (c_mon) begin
                c_year = q.mem[`BCC_A_MON] == 8'h12;
                d.mem[`BCC_A_MON] = c_year ? 8'h01 : bcd_inc(q.mem[`BCC_A_MON]);
            end
            if (c_year) begin
                d.mem[`BCC_A_YEAR] = (q.mem[`BCC_A_YEAR] == 8'h99) ? 8'h00 : bcd_inc(q.mem[`BCC_A_YEAR]);
            end
        end

        // capture address and data while the synced strobe is low
        if (wr_act) begin
            d.wa = q.s2.addr;
            d.wd = q.s2.data;
        end

        // an ended write of the flag byte clears every flag
        if (wr_done && !block1 && q.wa == `BCC_A_PFLAG) begin
            d.pflag = 8'h00;
        end
        // an ended read clears as well; address still held by the host
        if (rd_done && !block1 && q.s2.addr == `BCC_A_PFLAG) begin
            d.pflag = 8'h00;
        end

        // commit after the strobe ends, on top of any increment
        if (wr_done) begin
            if (q.wa == `BCC_A_MSR) begin
                // writing one clears alarm and periodic flags
                if (q.wd[`BCC_MSR_PER]) begin
                    d.msr[`BCC_MSR_PER] = 1'b0;
                end
                if (q.wd[`BCC_MSR_ALM]) begin
                    d.msr[`BCC_MSR_ALM] = 1'b0;
                end
                d.msr[`BCC_MSR_BLOCK] = q.wd[`BCC_MSR_BLOCK];
            end else if (q.wa <= `BCC_A_PAGE_LAST) begin
                if (block1) begin
                    d.pg1[3'(q.wa - 5'h01)] = q.wd;
                end else if (q.wa != `BCC_A_PFLAG) begin
                    d.mem[q.wa] = q.wd;
                end
            end else if (q.wa == `BCC_A_TWOBIT) begin
                d.mem[q.wa] = q.wd & `BCC_MASK_TWOBIT;
            end else if (q.wa < `BCC_A_NA_FIRST || q.wa > `BCC_A_NA_LAST) begin
                // counters hold whatever the host last wrote
                d.mem[q.wa] = q.wd;
            end
        end

        // enabled periodic event raises the status flag, set beats clear
        d.pflag = d.pflag | per_set;
        if (|(per_set & icr0)) begin
            d.msr[`BCC_MSR_PER] = 1'b1;
        end
        if (q.tick_dly && alarm_match) begin
            d.msr[`BCC_MSR_ALM] = 1'b1;
        end
        d.msr[`BCC_MSR_INT] = 1'b0;
        d.msr[`BCC_MSR_PFAIL] = 1'b0;

        // copy counters every cycle while enabled
        // freezing is just stopping the copy; one clock, so coherent
        // with enable low these bytes keep host data
        if (d.mem[`BCC_A_TSCTL][`BCC_TS_EN]) begin
            // only the used bit positions are overwritten
            d.mem[`BCC_A_TS_SEC] = merge(d.mem[`BCC_A_TS_SEC], d.mem[`BCC_A_SEC], `BCC_MASK_SEC);
            d.mem[`BCC_A_TS_MIN] = merge(d.mem[`BCC_A_TS_MIN], d.mem[`BCC_A_MIN], `BCC_MASK_MIN);
            d.mem[`BCC_A_TS_HOUR] = merge(d.mem[`BCC_A_TS_HOUR], d.mem[`BCC_A_HOUR], `BCC_MASK_HOUR);
            d.mem[`BCC_A_TS_DOM] = merge(d.mem[`BCC_A_TS_DOM], d.mem[`BCC_A_DOM], `BCC_MASK_DOM);
            d.mem[`BCC_A_TS_MON] = merge(d.mem[`BCC_A_TS_MON], d.mem[`BCC_A_MON], `BCC_MASK_MON);
        end

        // read data is sampled every cycle the read is active
        if (q.s2.addr == `BCC_A_MSR) begin
            rd_val = {q.msr[7:1], intr};
        end else if (q.s2.addr <= `BCC_A_PAGE_LAST) begin
            if (block1) begin
                rd_val = q.pg1[3'(q.s2.addr - 5'h01)];
            end else if (q.s2.addr == `BCC_A_PFLAG) begin
                rd_val = q.pflag;
            end else begin
                rd_val = q.mem[q.s2.addr];
            end
        end else begin
            rd_val = q.mem[q.s2.addr];
        end
        if (rd_act) begin
            d.rdata = rd_val;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.s1 <= '1;
            q.s2 <= '1;
        end else begin
            q <= d;
        end
    end

    assign data_out = q.rdata;
    assign data_oe_n_out = !q.rd_prev;
    // open drain: pin value low, enable low when asserting
    assign intr_n_out = 1'b0;
    assign intr_oe_n_out = !intr;

endmodule : bcc_core

// ### testbench/bcc_core_asserts.sv
module bcc_core_asserts #(
    parameter int PRE_DIV1 = 781,
    parameter int PRE_DIV2 = 320
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n_out,
    input wire logic intr_n_out,
    input wire logic intr_oe_n_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_read_drives_bus:
        assert property ((!cs_n_in && !rd_n_in) [*3] |=> !data_oe_n_out) else $error("bus not driven in read");
    a_idle_releases_bus:
        assert property ((cs_n_in || rd_n_in) [*3] |=> data_oe_n_out) else $error("bus driven when idle");
    a_drive_needs_read:
        assert property (!data_oe_n_out |-> $past(!cs_n_in && !rd_n_in, 3)) else $error("drive without read");
    a_write_no_drive:
        assert property ((!cs_n_in && !wr_n_in) [*3] |=> data_oe_n_out) else $error("bus driven in write");
    a_drive_min_span:
        assert property ($fell(data_oe_n_out) |-> !data_oe_n_out [*3]) else $error("drive too short");
    a_data_holds_idle:
        assert property (data_oe_n_out && $past(data_oe_n_out) |-> $stable(data_out)) else $error("data moved");
    a_intr_clear_write:
        assert property ($rose(intr_oe_n_out) |-> $past(!cs_n_in && !wr_n_in, 4)) else $error("intr cleared");
    a_intr_open_drain:
        assert property (intr_n_out == 1'b0) else $error("intr pin value high");
endmodule : bcc_core_asserts

bind bcc_core bcc_core_asserts #(.PRE_DIV1(PRE_DIV1), .PRE_DIV2(PRE_DIV2)) bcc_core_asserts_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in),
    .wr_n_in(wr_n_in), .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
    .data_oe_n_out(data_oe_n_out), .intr_n_out(intr_n_out), .intr_oe_n_out(intr_oe_n_out));

// ### testbench/bcc_host_model.sv
module bcc_host_model (
    input wire logic clock_in,
    output logic cs_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [4:0] addr_out,
    output logic [7:0] data_out,
    input wire logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 5'h00;
        data_out = 8'h00;
    end

    // strobes low 4 cycles, idle 4: the device needs 3 of each to sync
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clock_in);
        #1;
        addr_out = a;
        data_out = d;
        cs_n_out = 1'b0;
        rd_n_out = wr;
        wr_n_out = !wr;
        repeat (4) @(posedge clock_in);
        q = data_in;
        #1;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        repeat (4) @(posedge clock_in);
        #1;
        // released bus shows junk, never the old byte
        data_out = ~d;
    endtask : access
endmodule : bcc_host_model

// ### testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [4:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } bcc_row_t;

    logic clock_in;
    logic rst_n_in;
    logic cs_n, rd_n, wr_n, oe_n, intr_n, intr_oe_n;
    logic [4:0] addr;
    logic [7:0] wd, rdat, q;
    int failures;
    int n_tests;
    int cycles;
    // the test location 0x1F is never written
    bcc_row_t rows [10] = '{'{5'h0C, 8'h5A, 8'h5A}, '{5'h1E, 8'hA5, 8'hA5}, '{5'h13, 8'h59, 8'h59},
        '{5'h17, 8'h12, 8'h12}, '{5'h19, 8'hC3, 8'hC3}, '{5'h0D, 8'hFF, 8'h03}, '{5'h0F, 8'hFF, 8'h00},
        '{5'h12, 8'hFF, 8'h00}, '{5'h06, 8'h59, 8'h59}, '{5'h04, 8'h66, 8'h66}};
    logic [7:0] pre [8] = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h07};
    logic [7:0] post [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01};
    logic [15:0] h12 [3] = '{16'h1192, 16'h9281, 16'h9112};

    bcc_host_model bcc_host_model_i (.clock_in(clock_in), .cs_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .addr_out(addr), .data_out(wd), .data_in(rdat));

    bcc_core #(.PRE_DIV1(2), .PRE_DIV2(3)) bcc_core_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wd), .data_out(rdat),
        .data_oe_n_out(oe_n), .intr_n_out(intr_n), .intr_oe_n_out(intr_oe_n));

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    task automatic tally_and_finish();
        if (failures == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic w(input logic [4:0] a, input logic [7:0] d);
        bcc_host_model_i.access(1'b1, a, d, q);
    endtask : w

    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        bcc_host_model_i.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask : rc

    // one start/stop pair keeps run high 9 cycles: exactly one tick of 6
    task automatic run(input logic [7:0] m);
        w(5'h01, m | 8'h08);
        w(5'h01, m);
    endtask : run

    function automatic logic [4:0] ad(input int i);
        return (i < 7) ? 5'(5 + i) : 5'h0E;
    endfunction : ad

    initial begin
        failures = 0;
        n_tests = 0;
        cycles = 0;
        rst_n_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        rst_n_in = 1'b1;
        chk(8'(oe_n), 8'h01);
        rc(5'h05, 8'h00);
        foreach (rows[i]) begin
            w(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e);
        end
        w(5'h00, 8'h40);
        w(5'h04, 8'h77);
        rc(5'h04, 8'h77);
        rc(5'h00, 8'h40);
        w(5'h00, 8'h00);
        rc(5'h04, 8'h66);
        w(5'h05, 8'h00);
        repeat (3) run(8'h00);
        rc(5'h05, 8'h03);
        repeat (20) @(posedge clock_in);
        rc(5'h05, 8'h03);
        for (int i = 0; i < 8; i++) begin
            w(ad(i), pre[i]);
        end
        run(8'h00);
        for (int i = 0; i < 8; i++) begin
            rc(ad(i), post[i]);
        end
        // mode bits go in with run held clear
        w(5'h01, 8'h04);
        foreach (h12[i]) begin
            for (int j = 0; j < 3; j++) begin
                w(ad(j), pre[j]);
            end
            w(5'h08, h12[i][15:8]);
            run(8'h04);
            rc(5'h08, h12[i][7:0]);
        end
        w(5'h06, 8'h42);
        w(5'h19, 8'hFF);
        w(5'h02, 8'h80);
        w(5'h02, 8'h00);
        w(5'h06, 8'h17);
        rc(5'h19, 8'hC2);
        w(5'h00, 8'h40);
        w(5'h03, 8'h01);
        w(5'h00, 8'h00);
        w(5'h03, 8'h00);
        rc(5'h03, 8'h00);
        run(8'h04);
        chk(8'(intr_oe_n), 8'h00);
        rc(5'h03, 8'h01);
        rc(5'h03, 8'h00);
        rc(5'h00, 8'h05);
        w(5'h00, 8'h00);
        chk(8'(intr_oe_n), 8'h00);
        w(5'h00, 8'h04);
        chk(8'(intr_oe_n), 8'h01);
        rc(5'h03, 8'h00);
        rc(5'h06, 8'h17);
        rc(5'h03, 8'h00);
        tally_and_finish();
    end
endmodule : tb
